// [vip_pkg.sv]
// Constants for the vectored interrupt and power-mode controller
package vip_pkg;
    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_TOP = 16'hffff;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    localparam logic [15:0] VEC_COMP = 16'hfff6;
    localparam logic [15:0] VEC_WDOG = 16'hfff4;
    localparam logic [15:0] VEC_TMR0 = 16'hfff2;
    localparam logic [15:0] VEC_TMR1 = 16'hfff0;
    localparam logic [15:0] VEC_PORT2 = 16'hffe6;
    localparam logic [15:0] VEC_PORT1 = 16'hffe4;
    localparam logic [15:0] VEC_KEY = 16'hffde;
    localparam logic [15:0] VEC_FREE_TOP = 16'hffdc;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [15:0] KEY_LOADER_OFF = 16'haa55;
    localparam logic [15:0] KEY_NO_ERASE = 16'h0000;
    // ------------------------------------------------------------
    // Priorities
    // ------------------------------------------------------------
    localparam logic [4:0] PRI_RESET = 5'h1f;
    localparam logic [4:0] PRI_NMI = 5'h1e;
    localparam logic [4:0] PRI_COMP = 5'h1b;
    localparam logic [4:0] PRI_WDOG = 5'h1a;
    localparam logic [4:0] PRI_TMR0 = 5'h19;
    localparam logic [4:0] PRI_TMR1 = 5'h18;
    localparam logic [4:0] PRI_PORT2 = 5'h13;
    localparam logic [4:0] PRI_PORT1 = 5'h12;
    // ------------------------------------------------------------
    // Fetch ranges
    // ------------------------------------------------------------
    localparam logic [15:0] PERIPH_LO = 16'h0000;
    localparam logic [15:0] PERIPH_HI = 16'h01ff;
    localparam logic [15:0] UNUSED_A_LO = 16'h0300;
    localparam logic [15:0] UNUSED_A_END = 16'h0c00;
    localparam logic [15:0] UNUSED_B_LO = 16'h1100;
    // ------------------------------------------------------------
    // Maskable source index
    // ------------------------------------------------------------
    localparam int NUM_MASK = 6;
    localparam int SRC_COMP = 5;
    localparam int SRC_WDOG = 4;
    localparam int SRC_TMR0 = 3;
    localparam int SRC_TMR1 = 2;
    localparam int SRC_PORT2 = 1;
    localparam int SRC_PORT1 = 0;
    // ------------------------------------------------------------
    // Power states and flag reset values
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        run_state, sleep_state_zero, sleep_state_one,
        sleep_state_two, sleep_state_three, sleep_state_four
    } vip_pwr_t;
    localparam logic POR_FLAG_RST = 1'b1;
    localparam logic EXT_FLAG_RST = 1'b0;
endpackage : vip_pkg

// [vip_ctrl.sv]
// Interrupt vector dispatch and low-power clock gating
`timescale 1ns/1ps
module vip_ctrl #(
    parameter logic [15:0] CODE_LO = 16'hfc00 // Lowest used code address
) (
    input wire logic mclk_i, // Clock
    input wire logic reset_n_i, // Sync reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic power_up_i, // Supply power-up event
    input wire logic ext_reset_i, // Reset pin in reset mode
    input wire logic watchdog_flag_i, // Watchdog overflow
    input wire logic flash_key_violation_flag_i, // Flash key violation
    input wire logic pin_nmi_flag_i, // Pin non-maskable event
    input wire logic oscillator_fault_flag_i, // Oscillator fault
    input wire logic flash_access_violation_flag_i, // Flash access violation
    input wire logic nmi_en_i, // Pin event enable
    input wire logic osc_fault_en_i, // Oscillator fault enable
    input wire logic acc_viol_en_i, // Access violation enable
    input wire logic [5:0] mask_req_i, // Maskable requests from modules
    input wire logic gie_i, // Global interrupt enable
    input wire logic fetch_i, // CPU instruction fetch strobe
    input wire logic [15:0] fetch_addr_i, // Fetch address
    input wire logic [15:0] reset_vec_word_i, // Word at reset vector
    input wire logic [15:0] key_word_i, // Loader security key word
    input wire logic [2:0] sr_mode_i, // Status register sleep select
    input wire logic sr_load_i, // Status register sleep write
    input wire logic int_ack_i, // CPU took the vector
    input wire logic reti_i, // Handler return
    output logic sys_reset_o, // Reset request to core
    output logic int_req_o, // Interrupt request to core
    output logic [15:0] vec_addr_o, // Vector address to fetch
    output logic [4:0] int_pri_o, // Priority of request
    output logic cpu_run_o, // CPU executing
    output logic main_clk_en_o, // Main clock enable
    output logic sub_clk_en_o, // Peripheral sub clock enable
    output logic aux_clk_en_o, // Auxiliary clock enable
    output logic osc_gen_en_o, // Oscillator generator enable
    output logic xtal_en_o, // Crystal oscillator enable
    output logic power_on_flag_o, // Power-on flag
    output logic external_reset_flag_o, // External reset flag
    output logic loader_off_o, // Loader disabled
    output logic erase_block_o // Erase blocked on bad password
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    vip_pkg::vip_pwr_t mode_r;
    vip_pkg::vip_pwr_t saved_r;
    logic in_isr_r;
    logic dco_used_r;
    logic boot_chk_r;
    logic rst_cause;
    logic bad_fetch;
    logic nmi_req;
    logic [15:0] vec_nxt;
    logic [4:0] pri_nxt;
    logic req_nxt;
    logic [15:0] vec_tab [vip_pkg::NUM_MASK];
    logic [4:0] pri_tab [vip_pkg::NUM_MASK];

    // ------------------------------------------------------------
    // Maskable vector table
    // ------------------------------------------------------------
    assign vec_tab[vip_pkg::SRC_COMP] = vip_pkg::VEC_COMP;
    assign vec_tab[vip_pkg::SRC_WDOG] = vip_pkg::VEC_WDOG;
    assign vec_tab[vip_pkg::SRC_TMR0] = vip_pkg::VEC_TMR0;
    assign vec_tab[vip_pkg::SRC_TMR1] = vip_pkg::VEC_TMR1;
    assign vec_tab[vip_pkg::SRC_PORT2] = vip_pkg::VEC_PORT2;
    assign vec_tab[vip_pkg::SRC_PORT1] = vip_pkg::VEC_PORT1;
    assign pri_tab[vip_pkg::SRC_COMP] = vip_pkg::PRI_COMP;
    assign pri_tab[vip_pkg::SRC_WDOG] = vip_pkg::PRI_WDOG;
    assign pri_tab[vip_pkg::SRC_TMR0] = vip_pkg::PRI_TMR0;
    assign pri_tab[vip_pkg::SRC_TMR1] = vip_pkg::PRI_TMR1;
    assign pri_tab[vip_pkg::SRC_PORT2] = vip_pkg::PRI_PORT2;
    assign pri_tab[vip_pkg::SRC_PORT1] = vip_pkg::PRI_PORT1;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // bad fetch range
    assign bad_fetch = fetch_i && ((fetch_addr_i <= vip_pkg::PERIPH_HI)
        || (fetch_addr_i >= vip_pkg::UNUSED_B_LO && fetch_addr_i < CODE_LO)
        || (fetch_addr_i >= vip_pkg::UNUSED_A_LO && fetch_addr_i < vip_pkg::UNUSED_A_END));
    assign rst_cause = power_up_i || ext_reset_i || watchdog_flag_i
        || flash_key_violation_flag_i || bad_fetch;
    assign nmi_req = (pin_nmi_flag_i && nmi_en_i) || (oscillator_fault_flag_i && osc_fault_en_i)
        || (flash_access_violation_flag_i && acc_viol_en_i);

    always_comb begin
        vec_nxt = vip_pkg::VEC_RESET;
        pri_nxt = vip_pkg::PRI_RESET;
        req_nxt = 1'b0;
        if (rst_cause) begin
            req_nxt = 1'b1;
        end else if (nmi_req) begin
            vec_nxt = vip_pkg::VEC_NMI;
            pri_nxt = vip_pkg::PRI_NMI;
            req_nxt = 1'b1;
        end else if (gie_i) begin
            for (int i = 0; i < vip_pkg::NUM_MASK; i++) begin
                if (mask_req_i[i]) begin
                    vec_nxt = vec_tab[i];
                    pri_nxt = pri_tab[i];
                    req_nxt = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Dispatch outputs
    // ------------------------------------------------------------
    // no source below key slot
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sys_reset_o <= 1'b0;
            int_req_o <= 1'b0;
            vec_addr_o <= vip_pkg::VEC_RESET;
            int_pri_o <= vip_pkg::PRI_RESET;
        end else if (ce_i) begin
            sys_reset_o <= rst_cause;
            int_req_o <= req_nxt && !rst_cause && !int_ack_i;
            vec_addr_o <= vec_nxt;
            int_pri_o <= pri_nxt;
        end
    end

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            mode_r <= vip_pkg::run_state;
            saved_r <= vip_pkg::run_state;
            in_isr_r <= 1'b0;
            boot_chk_r <= 1'b1;
        end else if (ce_i) begin
            boot_chk_r <= 1'b0;
            if (rst_cause) begin
                mode_r <= vip_pkg::run_state;
                in_isr_r <= 1'b0;
                boot_chk_r <= 1'b1;
            end else if (boot_chk_r && reset_vec_word_i == vip_pkg::ERASED_WORD) begin
                mode_r <= vip_pkg::sleep_state_four;
            end else if (int_ack_i && !in_isr_r) begin
                saved_r <= mode_r;
                mode_r <= vip_pkg::run_state;
                in_isr_r <= 1'b1;
            end else if (reti_i && in_isr_r) begin
                mode_r <= saved_r;
                in_isr_r <= 1'b0;
            end else if (sr_load_i) begin
                if (in_isr_r) begin
                    saved_r <= vip_pwr_decode(sr_mode_i);
                end else begin
                    mode_r <= vip_pwr_decode(sr_mode_i);
                end
            end
        end
    end

    function automatic vip_pkg::vip_pwr_t vip_pwr_decode(input logic [2:0] code);
        case (code)
            3'h1: vip_pwr_decode = vip_pkg::sleep_state_zero;
            3'h2: vip_pwr_decode = vip_pkg::sleep_state_one;
            3'h3: vip_pwr_decode = vip_pkg::sleep_state_two;
            3'h4: vip_pwr_decode = vip_pkg::sleep_state_three;
            3'h5: vip_pwr_decode = vip_pkg::sleep_state_four;
            default: vip_pwr_decode = vip_pkg::run_state;
        endcase
    endfunction : vip_pwr_decode

    // Oscillator in use while running
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dco_used_r <= 1'b1;
        end else if (ce_i && mode_r == vip_pkg::run_state) begin
            dco_used_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cpu_run_o <= 1'b1;
            main_clk_en_o <= 1'b1;
            sub_clk_en_o <= 1'b1;
            aux_clk_en_o <= 1'b1;
            osc_gen_en_o <= 1'b1;
            xtal_en_o <= 1'b1;
        end else if (ce_i) begin
            case (mode_r)
                vip_pkg::run_state: begin
                    cpu_run_o <= 1'b1;
                    main_clk_en_o <= 1'b1;
                    sub_clk_en_o <= 1'b1;
                    aux_clk_en_o <= 1'b1;
                    osc_gen_en_o <= 1'b1;
                    xtal_en_o <= 1'b1;
                end
                vip_pkg::sleep_state_zero: begin
                    cpu_run_o <= 1'b0;
                    main_clk_en_o <= 1'b0;
                    sub_clk_en_o <= 1'b1;
                    aux_clk_en_o <= 1'b1;
                    osc_gen_en_o <= 1'b1;
                    xtal_en_o <= 1'b1;
                end
                vip_pkg::sleep_state_one: begin
                    cpu_run_o <= 1'b0;
                    main_clk_en_o <= 1'b0;
                    sub_clk_en_o <= 1'b1;
                    aux_clk_en_o <= 1'b1;
                    osc_gen_en_o <= dco_used_r;
                    xtal_en_o <= 1'b1;
                end
                vip_pkg::sleep_state_two: begin
                    cpu_run_o <= 1'b0;
                    main_clk_en_o <= 1'b0;
                    sub_clk_en_o <= 1'b0;
                    aux_clk_en_o <= 1'b1;
                    osc_gen_en_o <= 1'b1;
                    xtal_en_o <= 1'b1;
                end
                vip_pkg::sleep_state_three: begin
                    cpu_run_o <= 1'b0;
                    main_clk_en_o <= 1'b0;
                    sub_clk_en_o <= 1'b0;
                    aux_clk_en_o <= 1'b1;
                    osc_gen_en_o <= 1'b0;
                    xtal_en_o <= 1'b1;
                end
                default: begin
                    cpu_run_o <= 1'b0;
                    main_clk_en_o <= 1'b0;
                    sub_clk_en_o <= 1'b0;
                    aux_clk_en_o <= 1'b0;
                    osc_gen_en_o <= 1'b0;
                    xtal_en_o <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reset flags and loader key
    // ------------------------------------------------------------
    // reset cause flags
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            power_on_flag_o <= vip_pkg::POR_FLAG_RST;
            external_reset_flag_o <= vip_pkg::EXT_FLAG_RST;
        end else if (ce_i) begin
            if (power_up_i) begin
                power_on_flag_o <= 1'b1;
                external_reset_flag_o <= 1'b0;
            end else if (ext_reset_i) begin
                external_reset_flag_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            loader_off_o <= 1'b0;
            erase_block_o <= 1'b0;
        end else if (ce_i) begin
            loader_off_o <= key_word_i == vip_pkg::KEY_LOADER_OFF;
            erase_block_o <= key_word_i == vip_pkg::KEY_NO_ERASE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_vec;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && rst_cause) |=> (sys_reset_o && vec_addr_o == 16'hfffe && int_pri_o == 5'h1f);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

    property p_bad_fetch;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && fetch_i && fetch_addr_i <= 16'h01ff) |=> sys_reset_o;
    endproperty
    a_bad_fetch: assert property (p_bad_fetch) else $error("bad fetch no reset");

    property p_nmi_vec;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && !rst_cause && pin_nmi_flag_i && nmi_en_i && !gie_i) |=> (vec_addr_o == 16'hfffc);
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");

    property p_comp_first;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && !rst_cause && !nmi_req && gie_i && mask_req_i[5]) |=> (vec_addr_o == 16'hfff6);
    endproperty
    a_comp_first: assert property (p_comp_first) else $error("priority wrong");

    property p_gie_mask;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && !rst_cause && !nmi_req && !gie_i) |=> !int_req_o;
    endproperty
    a_gie_mask: assert property (p_gie_mask) else $error("masked request raised");

    property p_sleep4;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && mode_r == vip_pkg::sleep_state_four) |=> (!aux_clk_en_o && !xtal_en_o && !cpu_run_o);
    endproperty
    a_sleep4: assert property (p_sleep4) else $error("sleep four clocks on");

    property p_sleep0;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && mode_r == vip_pkg::sleep_state_zero) |=> (!main_clk_en_o && sub_clk_en_o && aux_clk_en_o);
    endproperty
    a_sleep0: assert property (p_sleep0) else $error("sleep zero clocks wrong");

    property p_wake;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && !rst_cause && !boot_chk_r && int_ack_i && !in_isr_r) |=> ##1 cpu_run_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");

    property p_key;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (ce_i && key_word_i == 16'haa55) |=> loader_off_o;
    endproperty
    a_key: assert property (p_key) else $error("loader not disabled");
endmodule : vip_ctrl

// [vip_cpu_model.sv]
// Behavioural core model that takes vectors and returns from handlers
`timescale 1ns/1ps
module vip_cpu_model (
    input wire logic mclk_i, // Clock
    input wire logic reset_n_i, // Sync reset, active low
    input wire logic slow_i, // Late acknowledge
    input wire logic int_req_i, // Request from controller
    output logic int_ack_o, // Vector taken
    output logic reti_o // Handler return
);
    int cnt_r;
    // ------------------------------------------------------------
    // Handler sequence
    // ------------------------------------------------------------
    // ack then return
    always_ff @(posedge mclk_i) begin
        int_ack_o <= 1'b0;
        reti_o <= 1'b0;
        if (!reset_n_i) begin
            cnt_r <= 0;
        end else if (cnt_r == 0) begin
            if (int_req_i === 1'b1) begin
                cnt_r <= 1;
            end
        end else begin
            cnt_r <= cnt_r + 1;
            if (cnt_r == (slow_i ? 4 : 1)) begin
                int_ack_o <= 1'b1;
            end
            if (cnt_r == 12) begin
                reti_o <= 1'b1;
                cnt_r <= 0;
            end
        end
    end
endmodule : vip_cpu_model

// [vectored_interrupt_and_power_modes_bench.sv]
// Self-checking bench for the vector dispatch and power controller
`timescale 1ns/1ps
module vectored_interrupt_and_power_modes_bench;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] cause = 4'h0;
    logic [2:0] nmi_f = 3'h0;
    logic [2:0] nmi_e = 3'h0;
    logic [5:0] mreq = 6'h00;
    logic gie = 1'b0;
    logic fetch = 1'b0;
    logic [15:0] faddr = 16'hfc00;
    logic [15:0] rvec = 16'hfc00;
    logic [15:0] key = 16'h1234;
    logic [2:0] mode = 3'h0;
    logic sr_load = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic ack, ret, sys_rst, req, run, main_en, sub_en, aux_en, osc, xt, pof, erf, ldr, ers;
    logic [15:0] vec;
    logic [4:0] pri;
    wire logic [5:0] en6 = {run, main_en, sub_en, aux_en, osc, xt};
    int n_errors = 0;
    int total_checks = 0;

    vip_ctrl i_vip_ctrl (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .power_up_i(cause[0]),
        .ext_reset_i(cause[1]), .watchdog_flag_i(cause[2]), .flash_key_violation_flag_i(cause[3]),
        .pin_nmi_flag_i(nmi_f[0]), .oscillator_fault_flag_i(nmi_f[1]), .flash_access_violation_flag_i(nmi_f[2]),
        .nmi_en_i(nmi_e[0]), .osc_fault_en_i(nmi_e[1]), .acc_viol_en_i(nmi_e[2]), .mask_req_i(mreq),
        .gie_i(gie), .fetch_i(fetch), .fetch_addr_i(faddr), .reset_vec_word_i(rvec), .key_word_i(key),
        .sr_mode_i(mode), .sr_load_i(sr_load), .int_ack_i(ack), .reti_i(ret), .sys_reset_o(sys_rst),
        .int_req_o(req), .vec_addr_o(vec), .int_pri_o(pri), .cpu_run_o(run), .main_clk_en_o(main_en),
        .sub_clk_en_o(sub_en), .aux_clk_en_o(aux_en), .osc_gen_en_o(osc), .xtal_en_o(xt),
        .power_on_flag_o(pof), .external_reset_flag_o(erf), .loader_off_o(ldr), .erase_block_o(ers));

    vip_cpu_model i_vip_cpu_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_i(slow), .int_req_i(req),
        .int_ack_o(ack), .reti_o(ret));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc

    // Bounded wait: 0 request, 1 ack, 2 return, 3 reset
    task automatic wait_on(input int sel, input logic lvl);
        logic s;
        for (int i = 0; i < 60; i++) begin
            cyc(1);
            s = (sel == 0) ? req : (sel == 1) ? ack : (sel == 2) ? ret : sys_rst;
            if (s === lvl) return;
        end
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        test_done();
    endtask : wait_on

    task automatic load(input logic [2:0] m);
        @(posedge mclk_i);
        mode <= m;
        sr_load <= 1'b1;
        @(posedge mclk_i);
        sr_load <= 1'b0;
        cyc(4);
    endtask : load

    task automatic serve(input logic [5:0] set, input logic [5:0] clr, input logic [15:0] v, input logic [4:0] p);
        @(posedge mclk_i);
        mreq <= mreq | set;
        wait_on(0, 1'b1);
        chk(vec, v, "vector address");
        chk({11'h000, pri}, {11'h000, p}, "priority");
        wait_on(1, 1'b1);
        @(posedge mclk_i);
        mreq <= mreq & ~clr;
        cyc(1);
        chk({15'h0000, run}, 16'h0001, "cpu runs handler");
        wait_on(2, 1'b1);
    endtask : serve
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        cyc(1);
        chk({10'h000, en6}, 16'h003f, "run clocks");
        chk({10'h000, pof, erf, ldr, ers, sys_rst, req}, 16'h0020, "reset flags");
        $display("test reset done");
    endtask : t_reset

    task automatic t_modes();
        logic [5:0] ex [6] = '{6'h0f, 6'h0f, 6'h07, 6'h05, 6'h00, 6'h3f};
        for (int i = 0; i < 6; i++) begin
            load(3'((i + 1) % 6));
            chk({10'h000, en6}, {10'h000, ex[i]}, "clock gating");
        end
        // Enable low ignores a mode write
        @(posedge mclk_i);
        ce <= 1'b0;
        load(3'h5);
        chk({10'h000, en6}, 16'h003f, "enable low freezes");
        @(posedge mclk_i);
        ce <= 1'b1;
        $display("test modes done");
    endtask : t_modes

    task automatic t_table();
        logic [15:0] vt [6] = '{vip_pkg::VEC_PORT1, vip_pkg::VEC_PORT2, vip_pkg::VEC_TMR1,
            vip_pkg::VEC_TMR0, vip_pkg::VEC_WDOG, vip_pkg::VEC_COMP};
        logic [4:0] pt [6] = '{5'h12, 5'h13, 5'h18, 5'h19, 5'h1a, 5'h1b};
        @(posedge mclk_i);
        gie <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk_i);
            slow <= i[0];
            serve(6'h01 << i, 6'h01 << i, vt[i], pt[i]);
        end
        $display("test table done");
    endtask : t_table

    task automatic t_wake();
        load(3'h1);
        serve(6'h21, 6'h20, vip_pkg::VEC_COMP, 5'h1b);
        serve(6'h00, 6'h01, vip_pkg::VEC_PORT1, 5'h12);
        cyc(4);
        chk({10'h000, en6}, 16'h000f, "back to sleep");
        // Sleep bits cleared inside the handler
        @(posedge mclk_i);
        mreq <= 6'h01;
        wait_on(1, 1'b1);
        @(posedge mclk_i);
        mreq <= 6'h00;
        mode <= 3'h0;
        sr_load <= 1'b1;
        @(posedge mclk_i);
        sr_load <= 1'b0;
        wait_on(2, 1'b1);
        cyc(4);
        chk({10'h000, en6}, 16'h003f, "handler clears sleep");
        $display("test wake done");
    endtask : t_wake

    task automatic t_refuse();
        @(posedge mclk_i);
        gie <= 1'b0;
        mreq <= 6'h20;
        cyc(8);
        chk({15'h0000, req}, 16'h0000, "gie low masks");
        @(posedge mclk_i);
        mreq <= 6'h00;
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            nmi_f <= 3'h1 << i;
            cyc(8);
            chk({15'h0000, req}, 16'h0000, "own enable blocks");
            @(posedge mclk_i);
            nmi_e <= 3'h1 << i;
            wait_on(0, 1'b1);
            chk({pri, vec[10:0]}, {5'h1e, vip_pkg::VEC_NMI[10:0]}, "fault vector");
            wait_on(1, 1'b1);
            @(posedge mclk_i);
            nmi_f <= 3'h0;
            nmi_e <= 3'h0;
            wait_on(2, 1'b1);
        end
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_causes();
        logic [15:0] fa [4] = '{16'h0000, 16'h01ff, 16'h0300, 16'h1100};
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            fetch <= (i < 4);
            faddr <= fa[i % 4];
            cause <= (i < 4) ? 4'h0 : 4'h1 << (i - 4);
            wait_on(3, 1'b1);
            chk({pri, vec[10:0]}, {5'h1f, vip_pkg::VEC_RESET[10:0]}, "reset vector");
            @(posedge mclk_i);
            fetch <= 1'b0;
            cause <= 4'h0;
            wait_on(3, 1'b0);
        end
        chk({14'h0000, pof, erf}, 16'h0003, "ext flag set");
        @(posedge mclk_i);
        fetch <= 1'b1;
        faddr <= 16'hfc00;
        cyc(1);
        chk({15'h0000, sys_rst}, 16'h0000, "code fetch allowed");
        @(posedge mclk_i);
        fetch <= 1'b0;
        cause <= 4'h1;
        @(posedge mclk_i);
        cause <= 4'h0;
        cyc(4);
        chk({14'h0000, pof, erf}, 16'h0002, "power-up clears");
        $display("test causes done");
    endtask : t_causes

    task automatic t_key_erased();
        logic [15:0] kt [3] = '{16'haa55, 16'h0000, 16'h1234};
        logic [1:0] ke [3] = '{2'h2, 2'h1, 2'h0};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            key <= kt[i];
            cyc(4);
            chk({14'h0000, ldr, ers}, {14'h0000, ke[i]}, "loader key");
        end
        @(posedge mclk_i);
        rvec <= 16'hffff;
        cause <= 4'h4;
        wait_on(3, 1'b1);
        @(posedge mclk_i);
        cause <= 4'h0;
        wait_on(3, 1'b0);
        cyc(4);
        chk({10'h000, en6}, 16'h0000, "erased vector sleeps");
        @(posedge mclk_i);
        rvec <= 16'hfc00;
        $display("test key and erased done");
    endtask : t_key_erased

    initial begin
        t_reset();
        t_modes();
        t_table();
        t_wake();
        t_refuse();
        t_causes();
        t_key_erased();
        t_reset();
        test_done();
    end
endmodule : vectored_interrupt_and_power_modes_bench
